// File: include/odx_map.svh
// opcode and field constants for the transfer/arithmetic opcode decoder
// assumes bytes arrive one per cycle from the prefetch queue
`ifndef ODX_MAP_SVH
`define ODX_MAP_SVH

// ************************************************************
// first-byte opcodes and the adjust second byte
// ************************************************************
`define ODX_OP_SEG_LOAD      8'h8e
`define ODX_OP_SEG_STORE     8'h8c
`define ODX_OP_TABLE_XLT     8'hd7
`define ODX_OP_EA_LOAD       8'h8d
`define ODX_OP_FAR_DS        8'hc5
`define ODX_OP_FAR_ES        8'hc4
`define ODX_OP_FLAGS_TO_AH   8'h9f
`define ODX_OP_AH_TO_FLAGS   8'h9e
`define ODX_OP_UNP_ADD_ADJ   8'h37
`define ODX_OP_PKD_ADD_ADJ   8'h27
`define ODX_OP_UNP_SUB_ADJ   8'h3f
`define ODX_OP_PKD_SUB_ADJ   8'h2f
`define ODX_OP_MULT_ADJ      8'hd4
`define ODX_OP_DIV_ADJ       8'hd5
`define ODX_OP_BYTE_SEXT     8'h98
`define ODX_OP_WORD_SEXT     8'h99
`define ODX_ADJ_SECOND       8'h0a

// ************************************************************
// masked first-byte patterns (top six or seven bits)
// ************************************************************
`define ODX_PAT_ADD          6'h00
`define ODX_PAT_ADC          6'h04
`define ODX_PAT_SBB          6'h06
`define ODX_PAT_SUB          6'h0a
`define ODX_PAT_IMM_GRP      6'h20
`define ODX_PAT_UNARY_GRP    7'h7b

// ************************************************************
// reg-field selections
// ************************************************************
`define ODX_REG_SBB          3'h3
`define ODX_REG_NEG          3'h3
`define ODX_REG_MULU         3'h4
`define ODX_REG_MULS         3'h5
`define ODX_REG_DIVU         3'h6
`define ODX_REG_DIVS         3'h7
`define ODX_SEG_BIT          5

`endif

// File: include/odx_pkg.sv
// types for the transfer/arithmetic opcode decoder
// assumes odx_map.svh supplies the numeric constants
package odx_pkg;

  // decoded operation
  typedef enum logic [4:0] {
    ODX_NONE, ODX_SEG_LOAD, ODX_SEG_STORE, ODX_TABLE_XLT, ODX_EA_LOAD,
    ODX_FAR_DS, ODX_FAR_ES, ODX_FLAGS_TO_AH, ODX_AH_TO_FLAGS, ODX_ADD,
    ODX_ADC, ODX_SUB, ODX_SBB, ODX_UNP_ADD_ADJ, ODX_PKD_ADD_ADJ,
    ODX_UNP_SUB_ADJ, ODX_PKD_SUB_ADJ, ODX_MULU, ODX_MULS, ODX_NEG,
    ODX_DIVU, ODX_DIVS, ODX_MULT_ADJ, ODX_DIV_ADJ, ODX_BYTE_SEXT,
    ODX_WORD_SEXT, ODX_ILLEGAL
  } odx_op_e;

  // decoder sequencing states
  typedef enum logic [1:0] {
    ODX_ST_FIRST, ODX_ST_MODRM, ODX_ST_ADJ
  } odx_state_e;

  // control word to the execution unit
  typedef struct packed {
    odx_op_e     op;
    logic        word;
    logic        reg_dest;
    logic        sign_ext;
    logic [1:0]  imm_bytes;
    logic [1:0]  mode;
    logic [2:0]  reg_sel;
    logic [2:0]  rm_sel;
  } odx_ctl_s;

endpackage

// File: rtl/odx_decoder.sv
// opcode decoder for the data-transfer and arithmetic groups
// assumes one opcode byte per cycle on byte_valid from same-clock queue logic
`timescale 1ns/10ps
`default_nettype none
`include "odx_map.svh"

module odx_decoder (
  input  wire logic             sys_clk,    // 25 MHz processor clock
  input  wire logic             rst,        // asynchronous, active high
  input  wire logic             byte_valid, // queue presents a byte
  input  wire logic [7:0]       byte_data,  // instruction byte
  output var  odx_pkg::odx_ctl_s ctl,       // decoded controls
  output logic                  ctl_valid   // one-cycle pulse per instruction
);

  // ************************************************************
  // state
  // ************************************************************
  odx_pkg::odx_state_e state;     // sequencing state
  logic [7:0]          first;     // held first byte
  logic [7:0]          modrm;     // byte being classified as mod/reg/r-m

  assign modrm = byte_data;

  // ************************************************************
  // single-byte classification of a first byte
  // ************************************************************
  function automatic odx_pkg::odx_op_e single_op(input logic [7:0] b);
    odx_pkg::odx_op_e o;
    o = odx_pkg::ODX_NONE;
    case (b)
      `ODX_OP_TABLE_XLT:   o = odx_pkg::ODX_TABLE_XLT;
      `ODX_OP_FLAGS_TO_AH: o = odx_pkg::ODX_FLAGS_TO_AH;
      `ODX_OP_AH_TO_FLAGS: o = odx_pkg::ODX_AH_TO_FLAGS;
      `ODX_OP_UNP_ADD_ADJ: o = odx_pkg::ODX_UNP_ADD_ADJ;
      `ODX_OP_PKD_ADD_ADJ: o = odx_pkg::ODX_PKD_ADD_ADJ;
      `ODX_OP_UNP_SUB_ADJ: o = odx_pkg::ODX_UNP_SUB_ADJ;
      `ODX_OP_PKD_SUB_ADJ: o = odx_pkg::ODX_PKD_SUB_ADJ;
      `ODX_OP_BYTE_SEXT:   o = odx_pkg::ODX_BYTE_SEXT;
      `ODX_OP_WORD_SEXT:   o = odx_pkg::ODX_WORD_SEXT;
      default:             o = odx_pkg::ODX_NONE;
    endcase
    return o;
  endfunction

  // does this first byte need a mod/reg/r-m byte
  function automatic logic needs_modrm(input logic [7:0] b);
    logic n;
    n = 1'b0;
    case (b)
      `ODX_OP_SEG_LOAD, `ODX_OP_SEG_STORE, `ODX_OP_EA_LOAD,
      `ODX_OP_FAR_DS, `ODX_OP_FAR_ES: n = 1'b1;
      default: n = 1'b0;
    endcase
    if (b[7:2] == `ODX_PAT_ADD || b[7:2] == `ODX_PAT_ADC ||
        b[7:2] == `ODX_PAT_SUB || b[7:2] == `ODX_PAT_SBB ||
        b[7:2] == `ODX_PAT_IMM_GRP || b[7:1] == `ODX_PAT_UNARY_GRP) begin
      n = 1'b1;
    end
    return n;
  endfunction

  // operation selected by a first byte and its mod/reg/r-m byte
  function automatic odx_pkg::odx_op_e modrm_op(input logic [7:0] f,
                                                input logic [7:0] m);
    odx_pkg::odx_op_e o;
    o = odx_pkg::ODX_ILLEGAL;
    case (f)
      `ODX_OP_SEG_LOAD: if (!m[`ODX_SEG_BIT]) o = odx_pkg::ODX_SEG_LOAD;
      `ODX_OP_SEG_STORE: if (!m[`ODX_SEG_BIT]) o = odx_pkg::ODX_SEG_STORE;
      `ODX_OP_EA_LOAD:  o = odx_pkg::ODX_EA_LOAD;
      `ODX_OP_FAR_DS:   o = odx_pkg::ODX_FAR_DS;
      `ODX_OP_FAR_ES:   o = odx_pkg::ODX_FAR_ES;
      default: begin
        if (f[7:2] == `ODX_PAT_ADD) o = odx_pkg::ODX_ADD;
        else if (f[7:2] == `ODX_PAT_ADC) o = odx_pkg::ODX_ADC;
        else if (f[7:2] == `ODX_PAT_SUB) o = odx_pkg::ODX_SUB;
        else if (f[7:2] == `ODX_PAT_SBB) o = odx_pkg::ODX_SBB;
        else if (f[7:2] == `ODX_PAT_IMM_GRP) begin
          // only the borrow member of the immediate group belongs here
          if (m[5:3] == `ODX_REG_SBB) o = odx_pkg::ODX_SBB;
        end else if (f[7:1] == `ODX_PAT_UNARY_GRP) begin
          case (m[5:3])
            `ODX_REG_MULU: o = odx_pkg::ODX_MULU;
            `ODX_REG_MULS: o = odx_pkg::ODX_MULS;
            `ODX_REG_NEG:  o = odx_pkg::ODX_NEG;
            `ODX_REG_DIVU: o = odx_pkg::ODX_DIVU;
            `ODX_REG_DIVS: o = odx_pkg::ODX_DIVS;
            default:       o = odx_pkg::ODX_ILLEGAL;
          endcase
        end
      end
    endcase
    return o;
  endfunction

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= odx_pkg::ODX_ST_FIRST;
      first <= 8'h00;
    end else if (byte_valid) begin
      case (state)
        odx_pkg::ODX_ST_FIRST: begin
          first <= byte_data;
          if (byte_data == `ODX_OP_MULT_ADJ || byte_data == `ODX_OP_DIV_ADJ) begin
            state <= odx_pkg::ODX_ST_ADJ;
          end else if (needs_modrm(byte_data)) begin
            state <= odx_pkg::ODX_ST_MODRM;
          end
        end
        // second byte ends both two-byte forms
        odx_pkg::ODX_ST_MODRM: state <= odx_pkg::ODX_ST_FIRST;
        odx_pkg::ODX_ST_ADJ:   state <= odx_pkg::ODX_ST_FIRST;
        default:               state <= odx_pkg::ODX_ST_FIRST;
      endcase
    end
  end

  // ************************************************************
  // control word output
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl       <= '0;
      ctl_valid <= 1'b0;
    end else begin
      ctl_valid <= 1'b0;
      if (byte_valid) begin
        case (state)
          odx_pkg::ODX_ST_FIRST: begin
            // single-byte forms finish here; unknown bytes stay silent
            if (single_op(byte_data) != odx_pkg::ODX_NONE) begin
              ctl           <= '0;
              ctl.op        <= single_op(byte_data);
              ctl.word      <= byte_data == `ODX_OP_WORD_SEXT;
              ctl_valid     <= 1'b1;
            end
          end
          odx_pkg::ODX_ST_MODRM: begin
            ctl.op        <= modrm_op(first, modrm);
            ctl.mode      <= modrm[7:6];
            ctl.reg_sel   <= modrm[5:3];
            ctl.rm_sel    <= modrm[2:0];
            // seg moves, pointer loads and address loads are word-wide
            ctl.word      <= (first[7:2] == `ODX_PAT_ADD || first[7:2] == `ODX_PAT_ADC ||
                              first[7:2] == `ODX_PAT_SUB || first[7:2] == `ODX_PAT_SBB ||
                              first[7:2] == `ODX_PAT_IMM_GRP ||
                              first[7:1] == `ODX_PAT_UNARY_GRP) ? first[0] : 1'b1;
            // register-form arithmetic honours d; loads always target reg
            ctl.reg_dest  <= (first[7:6] == 2'b00) ? first[1] :
                             (first == `ODX_OP_SEG_STORE ||
                              first[7:2] == `ODX_PAT_IMM_GRP ||
                              first[7:1] == `ODX_PAT_UNARY_GRP) ? 1'b0 : 1'b1;
            if (first[7:2] == `ODX_PAT_IMM_GRP) begin
              ctl.sign_ext  <= first[1];
              ctl.imm_bytes <= (first[1:0] == 2'b01) ? 2'h2 : 2'h1;
            end else begin
              ctl.sign_ext  <= 1'b0;
              ctl.imm_bytes <= 2'h0;
            end
            ctl_valid     <= 1'b1;
          end
          odx_pkg::ODX_ST_ADJ: begin
            ctl           <= '0;
            if (byte_data != `ODX_ADJ_SECOND) begin
              ctl.op <= odx_pkg::ODX_ILLEGAL;
            end else if (first == `ODX_OP_MULT_ADJ) begin
              ctl.op <= odx_pkg::ODX_MULT_ADJ;
            end else begin
              ctl.op <= odx_pkg::ODX_DIV_ADJ;
            end
            ctl_valid     <= 1'b1;
          end
          default: ctl_valid <= 1'b0;
        endcase
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_XLT: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_TABLE_XLT |=> ctl_valid && ctl.op == odx_pkg::ODX_TABLE_XLT
    && state == odx_pkg::ODX_ST_FIRST) else $error("table translate misdecoded");
  AST_SEGLD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_SEG_LOAD ##1 byte_valid && !byte_data[5]
    |=> ctl_valid && ctl.op == odx_pkg::ODX_SEG_LOAD) else $error("segment load lost");
  AST_SEGST: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_SEG_STORE ##1 byte_valid && !byte_data[5]
    |=> ctl.op == odx_pkg::ODX_SEG_STORE && !ctl.reg_dest) else $error("segment store");
  AST_ADD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:2] == `ODX_PAT_ADD ##1 byte_valid
    |=> ctl.op == odx_pkg::ODX_ADD && ctl.word == $past(byte_data[0], 2)
    && ctl.reg_dest == $past(byte_data[1], 2)) else $error("add form wrong");
  AST_SBBI: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == 8'h81 ##1 byte_valid && byte_data[5:3] == `ODX_REG_SBB
    |=> ctl.op == odx_pkg::ODX_SBB && ctl.imm_bytes == 2'h2) else $error("borrow imm");
  AST_SEXT: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == 8'h83 ##1 byte_valid
    |=> ctl.sign_ext && ctl.imm_bytes == 2'h1) else $error("sign-extended imm wrong");
  AST_DIVS: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:1] == `ODX_PAT_UNARY_GRP ##1 byte_valid && byte_data[5:3] == 3'h7
    |=> ctl.op == odx_pkg::ODX_DIVS) else $error("signed divide wrong");
  AST_MADJ: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_MULT_ADJ ##1 byte_valid && byte_data == `ODX_ADJ_SECOND
    |=> ctl_valid && ctl.op == odx_pkg::ODX_MULT_ADJ) else $error("mult adjust wrong");
  // every pulse follows an accepted byte
  AST_ONEPULSE: assert property (ctl_valid |-> $past(byte_valid))
    else $error("control pulse without a byte");

  // ************************************************************
  // single-byte forms answer one cycle after the byte
  // ************************************************************
  AST_FLAGS_TO_HIGH_ACC: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_FLAGS_TO_AH |=> ctl_valid && ctl.op == odx_pkg::ODX_FLAGS_TO_AH)
    else $error("flags to high byte wrong");
  AST_HIGH_ACC_TO_FLAGS: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_AH_TO_FLAGS |=> ctl_valid && ctl.op == odx_pkg::ODX_AH_TO_FLAGS)
    else $error("high byte to flags wrong");
  AST_UADJ_ADD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_UNP_ADD_ADJ |=> ctl_valid && ctl.op == odx_pkg::ODX_UNP_ADD_ADJ)
    else $error("unpacked add adjust wrong");
  AST_PADJ_ADD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_PKD_ADD_ADJ |=> ctl_valid && ctl.op == odx_pkg::ODX_PKD_ADD_ADJ)
    else $error("packed add adjust wrong");
  AST_UADJ_SUB: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_UNP_SUB_ADJ |=> ctl_valid && ctl.op == odx_pkg::ODX_UNP_SUB_ADJ)
    else $error("unpacked subtract adjust wrong");
  AST_PADJ_SUB: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_PKD_SUB_ADJ |=> ctl_valid && ctl.op == odx_pkg::ODX_PKD_SUB_ADJ)
    else $error("packed subtract adjust wrong");
  // byte extension is a byte op, word extension a word op
  AST_BSEXT: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_BYTE_SEXT |=> ctl_valid && ctl.op == odx_pkg::ODX_BYTE_SEXT
    && !ctl.word) else $error("byte sign extend wrong");
  AST_WSEXT: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_WORD_SEXT |=> ctl_valid && ctl.op == odx_pkg::ODX_WORD_SEXT
    && ctl.word) else $error("word sign extend wrong");

  // ************************************************************
  // two-byte forms answer one cycle after the second byte
  // ************************************************************
  // bit5 set in the second byte has no segment register behind it
  AST_SEGBAD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_SEG_LOAD ##1 byte_valid && byte_data[5]
    |=> ctl_valid && ctl.op == odx_pkg::ODX_ILLEGAL) else $error("bad segment accepted");
  // the effective address always lands in the reg register
  AST_EALD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_EA_LOAD ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_EA_LOAD && ctl.reg_dest)
    else $error("address load wrong");
  AST_FARDS: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_FAR_DS ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_FAR_DS && ctl.word)
    else $error("far load data segment wrong");
  AST_FARES: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_FAR_ES ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_FAR_ES && ctl.word)
    else $error("far load extra segment wrong");
  AST_ADC: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:2] == `ODX_PAT_ADC ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_ADC) else $error("add with carry wrong");
  AST_SUB: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:2] == `ODX_PAT_SUB ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_SUB) else $error("subtract wrong");
  // d picks the destination in the register forms
  AST_REGD: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:2] == `ODX_PAT_SUB ##1 byte_valid
    |=> ctl.reg_dest == $past(byte_data[1], 2)) else $error("direction bit wrong");
  AST_SBBR: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:2] == `ODX_PAT_SBB ##1 byte_valid
    |=> ctl_valid && ctl.op == odx_pkg::ODX_SBB) else $error("register borrow wrong");
  // full-word immediate is not sign-extended
  AST_IMMW: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == 8'h81 ##1 byte_valid
    |=> ctl.word && !ctl.sign_ext) else $error("word immediate wrong");
  AST_MULU: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:1] == `ODX_PAT_UNARY_GRP ##1 byte_valid && byte_data[5:3] == `ODX_REG_MULU
    |=> ctl.op == odx_pkg::ODX_MULU) else $error("unsigned multiply wrong");
  AST_MULS: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:1] == `ODX_PAT_UNARY_GRP ##1 byte_valid && byte_data[5:3] == `ODX_REG_MULS
    |=> ctl.op == odx_pkg::ODX_MULS) else $error("signed multiply wrong");
  AST_NEG: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:1] == `ODX_PAT_UNARY_GRP ##1 byte_valid && byte_data[5:3] == `ODX_REG_NEG
    |=> ctl.op == odx_pkg::ODX_NEG) else $error("negate wrong");
  AST_DIVU: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data[7:1] == `ODX_PAT_UNARY_GRP ##1 byte_valid && byte_data[5:3] == `ODX_REG_DIVU
    |=> ctl.op == odx_pkg::ODX_DIVU) else $error("unsigned divide wrong");
  // the divide adjust needs the fixed second byte
  AST_DADJ: assert property (state == odx_pkg::ODX_ST_FIRST && byte_valid &&
    byte_data == `ODX_OP_DIV_ADJ ##1 byte_valid && byte_data == `ODX_ADJ_SECOND
    |=> ctl_valid && ctl.op == odx_pkg::ODX_DIV_ADJ) else $error("divide adjust wrong");

  COV_SINGLE: cover property (ctl_valid && ctl.op == odx_pkg::ODX_FLAGS_TO_AH);
  COV_MODRM:  cover property (ctl_valid && ctl.op == odx_pkg::ODX_FAR_ES);
  COV_ADJ:    cover property (ctl_valid && ctl.op == odx_pkg::ODX_DIV_ADJ);
  COV_MUL:    cover property (ctl_valid && ctl.op == odx_pkg::ODX_MULS);
  COV_BAD:    cover property (ctl_valid && ctl.op == odx_pkg::ODX_ILLEGAL);

endmodule
`default_nettype wire

// File: tb/odx_queue_model.sv
// prefetch queue model that hands opcode bytes to the decoder
// assumes the bench queues bytes through push() and sets the stall count
`timescale 1ns/10ps
`default_nettype none

module odx_queue_model (
  input  wire logic       sys_clk,      // processor clock
  input  wire logic       rst,          // asynchronous, active high
  input  wire logic [3:0] stall_cycles, // idle cycles after each byte
  output var  logic       byte_valid,   // byte presented this cycle
  output var  logic [7:0] byte_data     // instruction byte
);
  // ************************************************************
  // byte store
  // ************************************************************
  logic [7:0] fifo[$]; // bytes waiting to be presented
  logic [3:0] idle;    // idle cycles still to run

  // queue one byte for presentation
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask

  // one byte per edge, or slower when stalling; between bytes the data
  // is inverted so a stale byte can never pass for a fresh one
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
      idle       <= 4'h0;
    end else if (fifo.size() > 0 && idle == 4'h0) begin
      byte_valid <= 1'b1;
      byte_data  <= fifo.pop_front();
      idle       <= stall_cycles;
    end else begin
      byte_valid <= 1'b0;
      byte_data  <= ~byte_data;
      if (idle != 4'h0) begin
        idle <= idle - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/odx_decoder_tb.sv
// self-checking bench for the transfer/arithmetic opcode decoder
// assumes odx_pkg is compiled first and include/ is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "odx_map.svh"

module odx_decoder_tb;
  // ************************************************************
  // signals
  // ************************************************************
  logic              sys_clk;     // 25 MHz clock
  logic              rst;         // asynchronous reset
  logic [3:0]        stall;       // queue idle cycles per byte
  logic              byte_valid;  // queue strobe
  logic [7:0]        byte_data;   // queue byte
  odx_pkg::odx_ctl_s ctl;         // decoded controls
  logic              ctl_valid;   // decode pulse
  int                miscompares; // mismatch count
  int                checked;     // comparison count

  odx_queue_model i_odx_queue_model (.sys_clk(sys_clk), .rst(rst), .stall_cycles(stall),
    .byte_valid(byte_valid), .byte_data(byte_data));
  odx_decoder i_odx_decoder (.sys_clk(sys_clk), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .ctl(ctl), .ctl_valid(ctl_valid));

  // clock toggles every half period
  always #20 sys_clk = ~sys_clk;

  // ************************************************************
  // helpers
  // ************************************************************
  // compare one value and report a mismatch
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // print counts and verdict, then stop
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // wait a bounded time for the next pulse and check its operation
  task automatic wait_ctl(input odx_pkg::odx_op_e op);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge sys_clk);
      got = (ctl_valid === 1'b1);
    end
    if (!got) begin
      miscompares++;
      $display("ERROR ctl_valid expected 1 seen 0");
      end_sim();
    end
    chk("op", ctl.op, op);
  endtask

  // send one instruction and check the decoded operation and fields
  task automatic dec(input logic [7:0] b0, input logic [7:0] b1, input int n,
                     input odx_pkg::odx_op_e op);
    i_odx_queue_model.push(b0);
    if (n > 1) begin
      i_odx_queue_model.push(b1);
    end
    wait_ctl(op);
    if (n > 1 && op != odx_pkg::ODX_ILLEGAL && b0[7:1] != 7'h6a) begin
      chk("mode", 8'(ctl.mode), 8'(b1[7:6]));
      chk("reg_sel", 8'(ctl.reg_sel), 8'(b1[5:3]));
      chk("rm_sel", 8'(ctl.rm_sel), 8'(b1[2:0]));
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // segment moves, translate, address and pointer loads, flag moves
  task automatic t_transfer();
    dec(`ODX_OP_SEG_LOAD, 8'h18, 2, odx_pkg::ODX_SEG_LOAD);
    chk("reg_dest", ctl.reg_dest, 1'b1);
    dec(`ODX_OP_SEG_LOAD, 8'h38, 2, odx_pkg::ODX_ILLEGAL);
    dec(`ODX_OP_SEG_STORE, 8'hd8, 2, odx_pkg::ODX_SEG_STORE);
    chk("reg_dest", ctl.reg_dest, 1'b0);
    dec(`ODX_OP_SEG_STORE, 8'he0, 2, odx_pkg::ODX_ILLEGAL);
    dec(`ODX_OP_TABLE_XLT, 8'h00, 1, odx_pkg::ODX_TABLE_XLT);
    dec(`ODX_OP_EA_LOAD, 8'h46, 2, odx_pkg::ODX_EA_LOAD);
    chk("reg_dest", ctl.reg_dest, 1'b1);
    dec(`ODX_OP_FAR_DS, 8'h1e, 2, odx_pkg::ODX_FAR_DS);
    dec(`ODX_OP_FAR_ES, 8'h2c, 2, odx_pkg::ODX_FAR_ES);
    dec(`ODX_OP_FLAGS_TO_AH, 8'h00, 1, odx_pkg::ODX_FLAGS_TO_AH);
    dec(`ODX_OP_AH_TO_FLAGS, 8'h00, 1, odx_pkg::ODX_AH_TO_FLAGS);
  endtask

  // register forms, immediate group and decimal adjusts
  task automatic t_arith();
    dec(8'h01, 8'hd8, 2, odx_pkg::ODX_ADD);
    chk("word", ctl.word, 1'b1);
    chk("reg_dest", ctl.reg_dest, 1'b0);
    dec(8'h12, 8'hc1, 2, odx_pkg::ODX_ADC);
    chk("word", ctl.word, 1'b0);
    chk("reg_dest", ctl.reg_dest, 1'b1);
    dec(8'h2b, 8'h07, 2, odx_pkg::ODX_SUB);
    dec(8'h18, 8'hf2, 2, odx_pkg::ODX_SBB);
    dec(8'h83, 8'hdb, 2, odx_pkg::ODX_SBB);
    chk("imm_bytes", 8'(ctl.imm_bytes), 8'h01);
    chk("sign_ext", ctl.sign_ext, 1'b1);
    dec(8'h81, 8'hd9, 2, odx_pkg::ODX_SBB);
    chk("imm_bytes", 8'(ctl.imm_bytes), 8'h02);
    chk("sign_ext", ctl.sign_ext, 1'b0);
    dec(8'h80, 8'h18, 2, odx_pkg::ODX_SBB);
    chk("imm_bytes", 8'(ctl.imm_bytes), 8'h01);
    chk("word", ctl.word, 1'b0);
    dec(8'h80, 8'h00, 2, odx_pkg::ODX_ILLEGAL);
    dec(`ODX_OP_UNP_ADD_ADJ, 8'h00, 1, odx_pkg::ODX_UNP_ADD_ADJ);
    dec(`ODX_OP_PKD_ADD_ADJ, 8'h00, 1, odx_pkg::ODX_PKD_ADD_ADJ);
    dec(`ODX_OP_UNP_SUB_ADJ, 8'h00, 1, odx_pkg::ODX_UNP_SUB_ADJ);
    dec(`ODX_OP_PKD_SUB_ADJ, 8'h00, 1, odx_pkg::ODX_PKD_SUB_ADJ);
  endtask

  // multiply, negate, divide, adjusts and sign extension
  task automatic t_group();
    dec(8'hf7, 8'he0, 2, odx_pkg::ODX_MULU);
    chk("word", ctl.word, 1'b1);
    dec(8'hf6, 8'he9, 2, odx_pkg::ODX_MULS);
    chk("word", ctl.word, 1'b0);
    dec(8'hf7, 8'hd8, 2, odx_pkg::ODX_NEG);
    dec(8'hf7, 8'hc0, 2, odx_pkg::ODX_ILLEGAL);
    dec(8'hf7, 8'hf3, 2, odx_pkg::ODX_DIVU);
    dec(8'hf6, 8'h3f, 2, odx_pkg::ODX_DIVS);
    dec(`ODX_OP_MULT_ADJ, `ODX_ADJ_SECOND, 2, odx_pkg::ODX_MULT_ADJ);
    dec(`ODX_OP_MULT_ADJ, 8'h0b, 2, odx_pkg::ODX_ILLEGAL);
    dec(`ODX_OP_DIV_ADJ, `ODX_ADJ_SECOND, 2, odx_pkg::ODX_DIV_ADJ);
    dec(`ODX_OP_BYTE_SEXT, 8'h00, 1, odx_pkg::ODX_BYTE_SEXT);
    chk("word", ctl.word, 1'b0);
    dec(`ODX_OP_WORD_SEXT, 8'h00, 1, odx_pkg::ODX_WORD_SEXT);
    chk("word", ctl.word, 1'b1);
  endtask

  // foreign byte skipped, then back-to-back bytes, then a slow queue
  task automatic t_stream();
    i_odx_queue_model.push(8'h90);
    i_odx_queue_model.push(`ODX_OP_TABLE_XLT);
    i_odx_queue_model.push(`ODX_OP_BYTE_SEXT);
    i_odx_queue_model.push(8'h03);
    i_odx_queue_model.push(8'hc2);
    wait_ctl(odx_pkg::ODX_TABLE_XLT);
    wait_ctl(odx_pkg::ODX_BYTE_SEXT);
    wait_ctl(odx_pkg::ODX_ADD);
    chk("reg_dest", ctl.reg_dest, 1'b1);
    @(posedge sys_clk);
    stall <= 4'h3;
    dec(8'h2a, 8'h05, 2, odx_pkg::ODX_SUB);
    chk("word", ctl.word, 1'b0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sys_clk     = 1'b0;
    rst         = 1'b1;
    stall       = 4'h0;
    miscompares = 0;
    checked     = 0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("ctl_valid", ctl_valid, 1'b0);
    chk("op", ctl.op, odx_pkg::ODX_NONE);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_transfer();
    t_arith();
    t_group();
    t_stream();
    end_sim();
  end
endmodule

`default_nettype wire
